/* File: gate_ctrl_map.vh */
// constants for gate control and power mode logic
`ifndef GATE_CTRL_MAP_VH
`define GATE_CTRL_MAP_VH
`define CLK_PERIOD_NS 100
`define ADDR_DRV_TIMING 12'h000
`define ADDR_MAIN_CFG 12'h004
`define ADDR_FAULT_STAT 12'h008
`define ADDR_WARN_STAT 12'h00C
`define ADDR_COND_IN 12'h010
`define ADDR_MODE_STAT 12'h014
`define DEAD_STEP_NS 250
`define DEAD_STEP_CYC ((`DEAD_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DEAD_SEL_RST 3'h7
`define BLANK_BASE_NS 500
`define BLANK_BASE_CYC ((`BLANK_BASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BLANK_SEL_RST 2'h3
`define DUV_FILT_NS 10000
`define DUV_FILT_CYC ((`DUV_FILT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STARTUP_NS 35000
`define STARTUP_CYC ((`STARTUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CE_STBY_NS 1000000
`define CE_STBY_CYC ((`CE_STBY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SLEEP_WAKE_NS 250000
`define SLEEP_WAKE_CYC ((`SLEEP_WAKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BUS_WAKE_NS 150000
`define BUS_WAKE_CYC (`BUS_WAKE_NS / `CLK_PERIOD_NS + 1)
`define SLEEP_DLY_NS 100000
`define SLEEP_DLY_CYC ((`SLEEP_DLY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// fault status bits: [0] over temp, [1] in uv, [2] drv ov, [3] in ov,
// [4] buck uv, [5] mosfet uvlo, [6] mosfet oc, [7] 5v ldo uv
`define FAULT_W 8
`define FB_BUCK_UV 4
`define FB_DRV_UV 5
`define FB_SHORT 6
// warning status bits: [0] temp warn, [1] buck oc, [2] buck uv, [3] brownout
`define WARN_W 4
`define WB_BUCK_UV 2
`define WB_BROWNOUT 3
// main config bits
`define CFG_SLEEP 0
`define CFG_BUS_PU 1
`endif

/* File: gate_ctrl.v */
// three phase gate control, fault pin and power mode machine
`timescale 1ns/1ps
`default_nettype none
`include "gate_ctrl_map.vh"
module gate_ctrl #(
    parameter CE_STBY_CYC = `CE_STBY_CYC,
    parameter SLEEP_WAKE_CYC = `SLEEP_WAKE_CYC,
    parameter BUS_WAKE_CYC = `BUS_WAKE_CYC,
    parameter STARTUP_CYC = `STARTUP_CYC,
    parameter SLEEP_DLY_CYC = `SLEEP_DLY_CYC
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [2:0] gate_cmd_high,
    input wire [2:0] gate_cmd_low,
    input wire chip_enable,
    input wire bus_wake_in,
    input wire high_voltage_wake_in,
    input wire [`FAULT_W-1:0] fault_cond,
    input wire [`WARN_W-1:0] warn_cond,
    input wire [2:0] cur_spike,
    output reg [2:0] high_side_gate,
    output reg [2:0] low_side_gate,
    output reg fault_out_n,
    output reg fault_out_oe,
    output reg ldo12_en,
    output reg bus_pullup_en,
    output reg buck_en,
    output reg msg_init_en
);
    localparam ST_RUN = 2'h0;
    localparam ST_STBY = 2'h1;
    localparam ST_SLEEP = 2'h2;
    localparam CW = 20;
    localparam [CW-1:0] CE_STBY_C = CE_STBY_CYC;
    localparam [CW-1:0] SLEEP_WAKE_C = SLEEP_WAKE_CYC;
    localparam [CW-1:0] BUS_WAKE_C = BUS_WAKE_CYC;
    localparam [CW-1:0] STARTUP_C = STARTUP_CYC;
    localparam [CW-1:0] SLEEP_DLY_C = SLEEP_DLY_CYC;
    localparam [CW-1:0] DUV_C = `DUV_FILT_CYC;

    // low counter helper: saturating count of cycles a level stays low
    function [CW-1:0] low_count;
        input lvl;
        input [CW-1:0] cnt;
        begin
            if (lvl)
                low_count = {CW{1'b0}};
            else if (cnt == {CW{1'b1}})
                low_count = cnt;
            else
                low_count = cnt + 1'b1;
        end
    endfunction

    // synchronisers for pins
    reg [2:0] cmd_h_s1_ff, cmd_h_ff, cmd_l_s1_ff, cmd_l_ff;
    reg [2:0] spike_s1_ff, spike_ff;
    reg ce_s1_ff, ce_ff, ce_d_ff;
    reg bus_s1_ff, bus_ff, bus_d_ff;
    reg hv_s1_ff, hv_ff, hv_d_ff;
    reg [`FAULT_W-1:0] fc_s1_ff, fc_ff;
    reg [`WARN_W-1:0] wc_s1_ff, wc_ff;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmd_h_s1_ff <= 3'h0;
            cmd_h_ff <= 3'h0;
            cmd_l_s1_ff <= 3'h0;
            cmd_l_ff <= 3'h0;
            spike_s1_ff <= 3'h0;
            spike_ff <= 3'h0;
            ce_s1_ff <= 1'b0;
            ce_ff <= 1'b0;
            ce_d_ff <= 1'b0;
            bus_s1_ff <= 1'b1;
            bus_ff <= 1'b1;
            bus_d_ff <= 1'b1;
            hv_s1_ff <= 1'b1;
            hv_ff <= 1'b1;
            hv_d_ff <= 1'b1;
            fc_s1_ff <= {`FAULT_W{1'b0}};
            fc_ff <= {`FAULT_W{1'b0}};
            wc_s1_ff <= {`WARN_W{1'b0}};
            wc_ff <= {`WARN_W{1'b0}};
        end
        else
        begin
            cmd_h_s1_ff <= gate_cmd_high;
            cmd_h_ff <= cmd_h_s1_ff;
            cmd_l_s1_ff <= gate_cmd_low;
            cmd_l_ff <= cmd_l_s1_ff;
            spike_s1_ff <= cur_spike;
            spike_ff <= spike_s1_ff;
            ce_s1_ff <= chip_enable;
            ce_ff <= ce_s1_ff;
            ce_d_ff <= ce_ff;
            bus_s1_ff <= bus_wake_in;
            bus_ff <= bus_s1_ff;
            bus_d_ff <= bus_ff;
            hv_s1_ff <= high_voltage_wake_in;
            hv_ff <= hv_s1_ff;
            hv_d_ff <= hv_ff;
            fc_s1_ff <= fault_cond;
            fc_ff <= fc_s1_ff;
            wc_s1_ff <= warn_cond;
            wc_ff <= wc_s1_ff;
        end
    end

    wire ce_rise = ce_ff & ~ce_d_ff;
    wire bus_rise = bus_ff & ~bus_d_ff;
    wire hv_rise = hv_ff & ~hv_d_ff;

    // registers and mode state
    reg [2:0] dead_time_sel_ff;
    reg [1:0] blank_time_sel_ff;
    reg sleep_cmd_ff, bus_pu_cfg_ff;
    reg [`FAULT_W-1:0] fault_ff;
    reg [`WARN_W-1:0] warn_ff;
    reg [1:0] mode_ff;
    reg [CW-1:0] ce_low_ff, bus_low_ff, hv_low_ff, start_ff, sdly_ff;
    reg bus_armed_ff, hv_armed_ff, ce_armed_ff;
    wire enabled = ce_ff && (mode_ff == ST_RUN) && (start_ff == {CW{1'b0}});
    wire fault_any = |fault_ff;

    // apb decode
    wire acc = psel & penable & pready;
    wire wr = acc & pwrite;
    wire wr_timing = wr && (paddr == `ADDR_DRV_TIMING);
    wire wr_main = wr && (paddr == `ADDR_MAIN_CFG);
    wire wake = (mode_ff == ST_SLEEP) &&
        ((ce_rise && ce_armed_ff) || (bus_rise && bus_armed_ff) || (hv_rise && hv_armed_ff));
    wire buck_fault = fault_ff[`FB_BUCK_UV] | fc_ff[`FB_BUCK_UV];
    wire sleep_go = (mode_ff != ST_SLEEP) && !ce_ff && sleep_cmd_ff && !buck_fault &&
        (sdly_ff == SLEEP_DLY_C);
    reg [31:0] rd_mux;
    reg rd_ok;
    always @*
    begin
        rd_ok = 1'b1;
        case (paddr)
            `ADDR_DRV_TIMING: rd_mux = {27'h0, blank_time_sel_ff, dead_time_sel_ff};
            `ADDR_MAIN_CFG: rd_mux = {30'h0, bus_pu_cfg_ff, sleep_cmd_ff};
            `ADDR_FAULT_STAT: rd_mux = {24'h0, fault_ff};
            `ADDR_WARN_STAT: rd_mux = {28'h0, warn_ff};
            `ADDR_COND_IN: rd_mux = {20'h0, wc_ff, fc_ff};
            `ADDR_MODE_STAT: rd_mux = {29'h0, enabled, mode_ff};
            default:
            begin
                rd_mux = 32'h0;
                rd_ok = 1'b0;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end
        else
        begin
            // one wait state: ready in second access cycle
            pready <= psel & penable & ~pready;
            if (psel & penable & ~pready)
            begin
                prdata <= pwrite ? 32'h0 : rd_mux;
                pslverr <= ~rd_ok;
            end
        end
    end

    // configuration, defaults restored on wake
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dead_time_sel_ff <= `DEAD_SEL_RST;
            blank_time_sel_ff <= `BLANK_SEL_RST;
            sleep_cmd_ff <= 1'b0;
            bus_pu_cfg_ff <= 1'b0;
        end
        else if (wake)
        begin
            dead_time_sel_ff <= `DEAD_SEL_RST;
            blank_time_sel_ff <= `BLANK_SEL_RST;
            sleep_cmd_ff <= 1'b0;
            bus_pu_cfg_ff <= 1'b0;
        end
        else
        begin
            if (wr_timing)
            begin
                dead_time_sel_ff <= pwdata[2:0];
                blank_time_sel_ff <= pwdata[4:3];
            end
            if (wr_main)
            begin
                sleep_cmd_ff <= pwdata[`CFG_SLEEP];
                bus_pu_cfg_ff <= pwdata[`CFG_BUS_PU];
            end
        end
    end

    // gate path per half-bridge
    reg [CW-1:0] dt_ff [0:2];
    reg [CW-1:0] bl_ff [0:2];
    reg [CW-1:0] uv_ff [0:2];
    reg [2:0] side_ff;
    localparam [CW-1:0] DEAD_STEP_C = `DEAD_STEP_CYC;
    localparam [CW-1:0] BLANK_BASE_C = `BLANK_BASE_CYC;
    wire [CW-1:0] dead_sel_ext = {{(CW-3){1'b0}}, dead_time_sel_ff};
    wire [CW-1:0] dead_c = (dead_sel_ext + 1'b1) * DEAD_STEP_C;
    wire [CW-1:0] blank_c = BLANK_BASE_C << blank_time_sel_ff;
    reg [2:0] drv_uv_hit, short_hit;
    integer i;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            high_side_gate <= 3'h0;
            low_side_gate <= 3'h0;
            side_ff <= 3'h0;
            drv_uv_hit <= 3'h0;
            short_hit <= 3'h0;
            for (i = 0; i < 3; i = i + 1)
            begin
                dt_ff[i] <= {CW{1'b0}};
                bl_ff[i] <= {CW{1'b0}};
                uv_ff[i] <= {CW{1'b0}};
            end
        end
        else
        begin
            for (i = 0; i < 3; i = i + 1)
            begin
                drv_uv_hit[i] <= 1'b0;
                short_hit[i] <= 1'b0;
                if (!enabled || fault_any || (cmd_h_ff[i] && cmd_l_ff[i]) ||
                    !(cmd_h_ff[i] || cmd_l_ff[i]))
                begin
                    high_side_gate[i] <= 1'b0;
                    low_side_gate[i] <= 1'b0;
                    dt_ff[i] <= {CW{1'b0}};
                    bl_ff[i] <= {CW{1'b0}};
                    uv_ff[i] <= {CW{1'b0}};
                end
                else if (side_ff[i] != cmd_h_ff[i])
                begin
                    // side change: all off, restart dead time
                    side_ff[i] <= cmd_h_ff[i];
                    high_side_gate[i] <= 1'b0;
                    low_side_gate[i] <= 1'b0;
                    dt_ff[i] <= {CW{1'b0}};
                    bl_ff[i] <= {CW{1'b0}};
                    uv_ff[i] <= {CW{1'b0}};
                end
                else if (dt_ff[i] < dead_c)
                    dt_ff[i] <= dt_ff[i] + 1'b1;
                else
                begin
                    high_side_gate[i] <= side_ff[i];
                    low_side_gate[i] <= ~side_ff[i];
                    if (bl_ff[i] < blank_c)
                        bl_ff[i] <= bl_ff[i] + 1'b1;
                    else if (spike_ff[i])
                        short_hit[i] <= 1'b1;
                    // filter time extended by the full blanking time blank_c, whether or not blanking is in progress
                    if (fc_ff[`FB_DRV_UV])
                    begin
                        if (uv_ff[i] < DUV_C + blank_c)
                            uv_ff[i] <= uv_ff[i] + 1'b1;
                        else
                            drv_uv_hit[i] <= 1'b1;
                    end
                    else
                        uv_ff[i] <= {CW{1'b0}};
                end
            end
        end
    end

    // status flags: set wins over clear
    wire [`FAULT_W-1:0] latch_mask = (`FAULT_W'h1 << `FB_DRV_UV) | (`FAULT_W'h1 << `FB_SHORT);
    wire [`FAULT_W-1:0] fault_set = (fc_ff & ~latch_mask) |
        ({`FAULT_W{|drv_uv_hit}} & (`FAULT_W'h1 << `FB_DRV_UV)) |
        ({`FAULT_W{|short_hit}} & (`FAULT_W'h1 << `FB_SHORT));
    wire [`FAULT_W-1:0] cond_now = (fc_ff & ~latch_mask) | fault_set;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fault_ff <= {`FAULT_W{1'b0}};
            warn_ff <= {`WARN_W{1'b0}};
        end
        else
        begin
            if (ce_rise)
                fault_ff <= (fault_ff & cond_now) | fault_set;
            else
                fault_ff <= fault_ff | fault_set;
            warn_ff <= warn_ff | wc_ff |
                ({`WARN_W{sleep_go}} & (`WARN_W'h1 << `WB_BROWNOUT));
        end
    end

    // enable-pin mode machine
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_ff <= ST_STBY;
            ce_low_ff <= {CW{1'b0}};
            bus_low_ff <= {CW{1'b0}};
            hv_low_ff <= {CW{1'b0}};
            start_ff <= STARTUP_C;
            sdly_ff <= {CW{1'b0}};
            bus_armed_ff <= 1'b0;
            hv_armed_ff <= 1'b0;
            ce_armed_ff <= 1'b0;
        end
        else
        begin
            ce_low_ff <= low_count(ce_ff, ce_low_ff);
            bus_low_ff <= low_count(bus_ff, bus_low_ff);
            hv_low_ff <= low_count(hv_ff, hv_low_ff);
            bus_armed_ff <= bus_low_ff >= BUS_WAKE_C;
            hv_armed_ff <= hv_low_ff >= SLEEP_WAKE_C;
            ce_armed_ff <= ce_low_ff >= SLEEP_WAKE_C;
            if (!ce_ff && sleep_cmd_ff && !buck_fault && mode_ff != ST_SLEEP)
            begin
                if (sdly_ff != SLEEP_DLY_C)
                    sdly_ff <= sdly_ff + 1'b1;
            end
            else
                sdly_ff <= {CW{1'b0}};
            if (ce_rise && mode_ff != ST_SLEEP)
                start_ff <= STARTUP_C;
            else if (start_ff != {CW{1'b0}})
                start_ff <= start_ff - 1'b1;
            case (mode_ff)
                ST_RUN:
                begin
                    if (sleep_go)
                        mode_ff <= ST_SLEEP;
                    else if (!ce_ff && ce_low_ff >= CE_STBY_C)
                        mode_ff <= ST_STBY;
                end
                ST_STBY:
                begin
                    if (sleep_go)
                        mode_ff <= ST_SLEEP;
                    else if (ce_rise)
                        mode_ff <= ST_RUN;
                end
                ST_SLEEP:
                begin
                    if (wake)
                    begin
                        mode_ff <= ST_STBY;
                        start_ff <= STARTUP_C;
                    end
                end
                default: mode_ff <= ST_STBY;
            endcase
        end
    end

    // power and pin outputs
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fault_out_n <= 1'b0;
            fault_out_oe <= 1'b0;
            ldo12_en <= 1'b0;
            bus_pullup_en <= 1'b0;
            buck_en <= 1'b1;
            msg_init_en <= 1'b0;
        end
        else
        begin
            fault_out_oe <= fault_any;
            ldo12_en <= (mode_ff == ST_RUN);
            bus_pullup_en <= (mode_ff == ST_RUN) | (mode_ff == ST_STBY && !bus_pu_cfg_ff);
            buck_en <= (mode_ff != ST_SLEEP);
            msg_init_en <= ce_ff && (mode_ff == ST_RUN);
        end
    end
endmodule
`default_nettype wire

/* File: gate_ctrl_chk.sv */
// assertion checker for the gate control and power mode block
`timescale 1ns/1ps
`default_nettype none
`include "gate_ctrl_map.vh"
module gate_ctrl_chk #(
    parameter int CE_STBY_CYC = 50
) (
    input wire pclk,
    input wire presetn,
    input wire [2:0] gate_cmd_high,
    input wire [2:0] gate_cmd_low,
    input wire chip_enable,
    input wire [`FAULT_W-1:0] fault_cond,
    input wire [2:0] high_side_gate,
    input wire [2:0] low_side_gate,
    input wire fault_out_n,
    input wire fault_out_oe,
    input wire ldo12_en,
    input wire buck_en,
    input wire msg_init_en
);
    logic [15:0] ce_low_ff;
    logic [15:0] nxt_ce_low;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // saturating count of enable-low cycles
    always_comb
    begin
        nxt_ce_low = ce_low_ff;
        if (chip_enable)
            nxt_ce_low = 16'h0000;
        else if (ce_low_ff != 16'hFFFF)
            nxt_ce_low = ce_low_ff + 16'h0001;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ce_low_ff <= 16'h0000;
        else
            ce_low_ff <= nxt_ce_low;
    end
    sequence ce_off_s;
        (!chip_enable) [*5];
    endsequence
    // raw short bit 6 and filtered driver uv bit 5 left out
    sequence fault_on_s;
        ((fault_cond & 8'h9F) != 8'h00) [*6];
    endsequence
    a_fault_pin_low: assert property (fault_on_s |-> fault_out_oe && !fault_out_n)
        else $error("fault pin not pulled low");
    a_fault_gates_off: assert property (fault_on_s |-> (high_side_gate | low_side_gate) == 3'h0)
        else $error("gates on during fault");
    a_cross_cond: assert property ((high_side_gate & low_side_gate) == 3'h0)
        else $error("both gates of a half-bridge on");
    a_break_make: assert property ($rose(high_side_gate[0]) |-> !$past(low_side_gate[0], 3))
        else $error("no dead time before turn on");
    a_both_cmd_off: assert property ((gate_cmd_high[0] && gate_cmd_low[0]) [*6] |->
        !high_side_gate[0] && !low_side_gate[0])
        else $error("gate on with both commands high");
    a_enable_gates_off: assert property (ce_off_s |-> (high_side_gate | low_side_gate) == 3'h0)
        else $error("gates on with enable low");
    a_no_msg_init: assert property (ce_off_s |-> !msg_init_en)
        else $error("message start allowed with enable low");
    a_startup_hold: assert property ($rose(chip_enable) |->
        ((high_side_gate | low_side_gate) == 3'h0) [*8])
        else $error("gates on during startup");
    a_standby_ldo: assert property (ce_low_ff > CE_STBY_CYC + 8 |-> !ldo12_en)
        else $error("ldo on in standby");
    a_buck_keep: assert property (fault_cond[`FB_BUCK_UV] && buck_en |=> buck_en)
        else $error("buck off with buck fault active");
endmodule
`default_nettype wire

/* File: host_model.sv */
// host side model: enable pin, wake lines, fault line pull-up
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic pclk,
    input wire logic fault_out_n,
    input wire logic fault_out_oe,
    output logic chip_enable,
    output logic bus_wake_in,
    output logic high_voltage_wake_in,
    output wire logic fault_pin
);
    assign fault_pin = fault_out_oe ? fault_out_n : 1'b1;
    initial
    begin
        chip_enable = 1'b0;
        bus_wake_in = 1'b1;
        high_voltage_wake_in = 1'b1;
    end
    task automatic ce_set(input logic v);
        @(posedge pclk);
        chip_enable <= v;
    endtask
    // low pulse of n clocks on enable
    task automatic ce_pulse(input int n);
        ce_set(1'b0);
        repeat (n) @(posedge pclk);
        chip_enable <= 1'b1;
    endtask
    // dominant bus for n clocks, then recessive
    task automatic bus_pulse(input int n);
        @(posedge pclk);
        bus_wake_in <= 1'b0;
        repeat (n) @(posedge pclk);
        bus_wake_in <= 1'b1;
    endtask
    task automatic hv_pulse(input int n);
        @(posedge pclk);
        high_voltage_wake_in <= 1'b0;
        repeat (n) @(posedge pclk);
        high_voltage_wake_in <= 1'b1;
    endtask
endmodule
`default_nettype wire

/* File: tb_gate_ctrl.sv */
// testbench for the gate control and power mode block
`timescale 1ns/1ps
`default_nettype none
module tb_gate_ctrl;
    localparam int STBY = 50;
    localparam int SWAKE = 30;
    localparam int BWAKE = 20;
    localparam int START = 10;
    localparam int SDLY = 10;
    localparam int DUV = 100;
    localparam int FB[6] = '{0, 1, 2, 3, 4, 7};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [2:0] cmd_hi = 3'h0;
    logic [2:0] cmd_lo = 3'h0;
    logic [7:0] fcond = 8'h00;
    logic [3:0] wcond = 4'h0;
    logic [2:0] spike = 3'h0;
    logic [31:0] q;
    logic serr;
    wire [31:0] prdata;
    wire pready, pslverr, ce, bus_w, hv_w, fpin, f_n, f_oe, ldo, pu, buck, msg;
    wire [2:0] hsg;
    wire [2:0] lsg;
    int fails = 0;
    int samples_checked = 0;
    always #50 pclk = ~pclk;
    gate_ctrl #(.CE_STBY_CYC(STBY), .SLEEP_WAKE_CYC(SWAKE), .BUS_WAKE_CYC(BWAKE),
        .STARTUP_CYC(START), .SLEEP_DLY_CYC(SDLY)) dut_u (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .gate_cmd_high(cmd_hi),
        .gate_cmd_low(cmd_lo), .chip_enable(ce), .bus_wake_in(bus_w),
        .high_voltage_wake_in(hv_w), .fault_cond(fcond), .warn_cond(wcond), .cur_spike(spike),
        .high_side_gate(hsg), .low_side_gate(lsg), .fault_out_n(f_n), .fault_out_oe(f_oe),
        .ldo12_en(ldo), .bus_pullup_en(pu), .buck_en(buck), .msg_init_en(msg));
    host_model host_u (.pclk(pclk), .fault_out_n(f_n), .fault_out_oe(f_oe),
        .chip_enable(ce), .bus_wake_in(bus_w), .high_voltage_wake_in(hv_w), .fault_pin(fpin));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h00000000);
        chk(q & m, e);
    endtask
    task automatic wait_hs(output int n);
        n = 0;
        do begin @(negedge pclk); n++; end while (hsg !== 3'h7 && n < 80);
    endtask
    task automatic t_startup;
        rdc(12'h000, 32'hFFFFFFFF, 32'h0000001F);
        rdc(12'h020, 32'hFFFFFFFF, 32'h00000000);
        chk({31'h0, serr}, 32'h1);
        rdc(12'h014, 32'h3, 32'h1);
        host_u.ce_set(1'b1);
        cmd_hi <= 3'h1;
        cyc(6);
        chk({29'h0, hsg}, 32'h0);
        cyc(START + 40);
        chk({30'h0, hsg[0], ldo}, 32'h3);
        rdc(12'h014, 32'h3, 32'h0);
        cmd_hi <= 3'h0;
    endtask
    task automatic t_dead;
        int n;
        for (int s = 0; s < 8; s++)
        begin
            apb(1'b1, 12'h000, {27'h0, 2'h3, s[2:0]});
            cmd_hi <= 3'h0;
            cmd_lo <= 3'h7;
            cyc(40);
            chk({29'h0, lsg}, 32'h7);
            cmd_hi <= 3'h7;
            cmd_lo <= 3'h0;
            wait_hs(n);
            chk({31'h0, n >= (s + 1) * 3 + 2 && n <= (s + 1) * 3 + 6}, 32'h1);
            @(posedge pclk);
        end
        cmd_lo <= 3'h7;
        cyc(40);
        chk({26'h0, hsg, lsg}, 32'h0);
        cmd_hi <= 3'h0;
        cmd_lo <= 3'h0;
    endtask
    task automatic t_blank;
        int n;
        apb(1'b1, 12'h000, 32'h00000018);
        cmd_hi <= 3'h7;
        wait_hs(n);
        @(posedge pclk);
        spike <= 3'h7;
        cyc(3);
        spike <= 3'h0;
        cyc(4);
        chk({31'h0, fpin}, 32'h1);
        cyc(60);
        spike <= 3'h7;
        cyc(10);
        spike <= 3'h0;
        cyc(20);
        chk({28'h0, fpin, hsg}, 32'h0);
        cmd_hi <= 3'h0;
        host_u.ce_pulse(10);
        cyc(START + 10);
        chk({31'h0, fpin}, 32'h1);
        rdc(12'h008, 32'hFF, 32'h0);
        // driver undervoltage: filter plus full blanking before latch
        cmd_hi <= 3'h7;
        wait_hs(n);
        @(posedge pclk);
        fcond <= 8'h20;
        cyc(DUV);
        chk({31'h0, fpin}, 32'h1);
        cyc(60);
        chk({28'h0, fpin, hsg}, 32'h0);
        rdc(12'h008, 32'hFF, 32'h20);
        fcond <= 8'h00;
        cmd_hi <= 3'h0;
        host_u.ce_pulse(10);
        cyc(START + 10);
        rdc(12'h008, 32'hFF, 32'h0);
    endtask
    task automatic t_faults;
        for (int i = 0; i < 6; i++)
        begin
            fcond <= 8'h01 << FB[i];
            cyc(8);
            chk({31'h0, fpin}, 32'h0);
            rdc(12'h008, 32'hFF, 32'h1 << FB[i]);
            host_u.ce_pulse(10);
            cyc(START + 10);
            rdc(12'h008, 32'hFF, 32'h1 << FB[i]);
            fcond <= 8'h00;
            cyc(8);
            host_u.ce_pulse(10);
            cyc(START + 10);
            chk({31'h0, fpin}, 32'h1);
            rdc(12'h008, 32'hFF, 32'h0);
        end
        for (int w = 0; w < 3; w++)
        begin
            wcond <= 4'h1 << w;
            cyc(8);
            chk({31'h0, fpin}, 32'h1);
            rdc(12'h00C, 32'h7, (32'h2 << w) - 32'h1);
        end
        wcond <= 4'h0;
    endtask
    task automatic go_sleep;
        apb(1'b1, 12'h004, 32'h1);
        cyc(SDLY + 20);
        rdc(12'h014, 32'h3, 32'h2);
    endtask
    task automatic t_power;
        apb(1'b1, 12'h004, 32'h2);
        cmd_hi <= 3'h7;
        host_u.ce_set(1'b0);
        cyc(STBY + 20);
        rdc(12'h014, 32'h3, 32'h1);
        chk({22'h0, hsg, lsg, ldo, pu, buck, msg}, 32'h2);
        cmd_hi <= 3'h0;
        fcond <= 8'h10;
        apb(1'b1, 12'h004, 32'h1);
        cyc(SDLY + 20);
        rdc(12'h014, 32'h3, 32'h1);
        chk({31'h0, buck}, 32'h1);
        fcond <= 8'h00;
        host_u.ce_set(1'b1);
        cyc(START + 10);
        host_u.ce_set(1'b0);
        cyc(STBY + SDLY + 20);
        rdc(12'h014, 32'h3, 32'h2);
        chk({31'h0, buck}, 32'h0);
        rdc(12'h00C, 32'h8, 32'h8);
        host_u.bus_pulse(BWAKE / 2);
        cyc(10);
        rdc(12'h014, 32'h3, 32'h2);
        host_u.bus_pulse(BWAKE + 14);
        cyc(10);
        rdc(12'h014, 32'h3, 32'h1);
        rdc(12'h000, 32'h1F, 32'h1F);
        go_sleep();
        host_u.hv_pulse(SWAKE + 5);
        cyc(10);
        rdc(12'h014, 32'h3, 32'h1);
        go_sleep();
        cyc(SWAKE);
        host_u.ce_set(1'b1);
        cyc(START + 10);
        rdc(12'h014, 32'h2, 32'h0);
        // raw short and brownout lines: readable, never a pin fault
        fcond <= 8'h40;
        wcond <= 4'h8;
        cyc(8);
        rdc(12'h010, 32'hFFF, 32'h840);
        chk({31'h0, fpin}, 32'h1);
        fcond <= 8'h00;
        wcond <= 4'h0;
    endtask
    task automatic test_done;
        $display("checks=%0d fails=%0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        cyc(20);
        presetn <= 1'b1;
        t_startup();
        t_dead();
        t_blank();
        t_faults();
        t_power();
        test_done();
    end
    initial
    begin
        cyc(60000);
        fails++;
        test_done();
    end
endmodule
bind gate_ctrl gate_ctrl_chk #(.CE_STBY_CYC(CE_STBY_CYC)) chk_u (.pclk(pclk),
    .presetn(presetn), .gate_cmd_high(gate_cmd_high), .gate_cmd_low(gate_cmd_low),
    .chip_enable(chip_enable), .fault_cond(fault_cond), .high_side_gate(high_side_gate),
    .low_side_gate(low_side_gate), .fault_out_n(fault_out_n), .fault_out_oe(fault_out_oe),
    .ldo12_en(ldo12_en), .buck_en(buck_en), .msg_init_en(msg_init_en));
`default_nettype wire
